// ### core/arsr_map.svh
/*
 * Register offsets, field positions and reset values of the autoreclose
 * shot/reset sequencer. Assumes a byte-addressed 32-bit Wishbone bus.
 */
`ifndef ARSR_MAP_SVH
`define ARSR_MAP_SVH

// Width of one timing setting, in bits
`define ARSR_TW         20
// Register byte offsets
`define ARSR_ADR_CTRL   8'h00
`define ARSR_ADR_OI1    8'h04
`define ARSR_ADR_OI2    8'h08
`define ARSR_ADR_OI3    8'h0c
`define ARSR_ADR_OI4    8'h10
`define ARSR_ADR_RSD    8'h14
`define ARSR_ADR_RSLD   8'h18
`define ARSR_ADR_STAT   8'h1c
// Control field positions
`define ARSR_CTRL_EN    0
`define ARSR_CTRL_CLOSE_UNLATCH  1
`define ARSR_CTRL_BRKI  2
// Reset values (ticks of the processing tick)
`define ARSR_RST_CTRL   3'h2
`define ARSR_RST_OI1    20'h001f4
`define ARSR_RST_OIX    20'h00000
`define ARSR_RST_RSD    20'h005dc
`define ARSR_RST_RSLD   20'h001f4
// Highest shot value
`define ARSR_SHOT_MAX   3'h4

`endif

// ### core/arsr_pkg.sv
/*
 * Types shared by the autoreclose sequencer.
 * Assumes arsr_map.svh supplies the numeric constants.
 */
package arsr_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_RESET,
    ST_CYCLE,
    ST_LOCKOUT
  } arsr_state_t;

  // One-hot shot position bits
  typedef struct packed {
    logic four;
    logic three;
    logic two;
    logic one;
    logic zero;
  } arsr_shot_pos_t;

  // Registered status seen on the pins and in the status register
  typedef struct packed {
    logic           close_out;
    logic           reset_timing_flag;
    logic           open_interval_timing_flag;
    logic [2:0]     shot;
    arsr_shot_pos_t pos;
    logic           lockout_state_flag;
    logic           cycle_state_flag;
    logic           reset_state_flag;
  } arsr_status_t;

endpackage

// ### core/arsr_core.sv
/*
 * Autoreclose reset timer, timing flags, shot counter and reclose
 * initiation, with a classic Wishbone register slave.
 * Assumes all inputs are synchronous to sys_clk and that proc_tick is a
 * one-cycle pulse marking each processing interval; all times count ticks.
 */
// Our own choices: the register offsets and the Wishbone slave port.
// What this block does
// - Reset state only after closed-breaker timeout
// - Cycle state times with reclose reset time
// - Sequence coordination uses reclose reset time
// - Lockout state times with lockout reset time
// - Power-up and setting change load lockout time
// - Both reset durations held independently
// - Block condition halts reset timer
// - Open interval flag only while timing
// - Open interval timing needs initiation, no stall
// - Reset flag only while reset timer counts
// - Shot starts zero, steps on interval expiry
// - Automatic reclosing saturates at last shot
// - Shot clears on return to reset
// - Shot decoded to one-hot position bits
// - Sequence coordination may pass last shot
// - Initiate rising edge with supervision starts timing
// - Unsupervised initiate edge goes to lockout
// - Trip initiates only closed or in cycle
// - Trip with breaker open during interval locks out
// - Breaker-open initiation needs trip asserted
// - Breaker opening without trip locks out
// - Close held until breaker reports closed, or until trip if unlatch set
// - Disabled or zero first interval defeats all
// - Last shot counts leading nonzero intervals
// - Setting change keeps state, drives last shot
// - Open intervals are timed one after another
`timescale 1ns/1ps
`include "arsr_map.svh"

module arsr_core
  import arsr_pkg::*;
#(
  parameter int TW = `ARSR_TW                  // Timing setting width
) (
  input  wire logic        sys_clk,            // 200 MHz clock
  input  wire logic        sys_rst,            // Sync reset, high
  input  wire logic        proc_tick,          // Processing interval pulse
  input  wire logic        breaker_closed_status, // Breaker closed
  input  wire logic        trip,               // Trip condition
  input  wire logic        reclose_initiate,   // Initiate condition
  input  wire logic        initiate_supervision, // Initiate supervision
  input  wire logic        stall_open_interval, // Stall interval timing
  input  wire logic        reset_timing_block, // Block reset timing
  input  wire logic        sequence_coordination, // Coordination op
  input  wire logic        close_conditions,   // Manual close request
  input  wire logic        group_switch,       // Active group changed
  input  wire logic        wb_cyc,             // Wishbone cycle
  input  wire logic        wb_stb,             // Wishbone strobe
  input  wire logic        wb_we,              // Wishbone write
  input  wire logic [7:0]  wb_adr,             // Byte address
  input  wire logic [3:0]  wb_sel,             // Byte lanes
  input  wire logic [31:0] wb_dat_w,           // Write data
  output logic      [31:0] wb_dat_r,           // Read data
  output logic             wb_ack,             // Acknowledge
  output arsr_status_t     status              // Flags and shot bits
);

  ////////////////////////////////////////////////////////////////////////
  // Settings and state
  logic [2:0]       ctrl;                      // Enable, unlatch, mode
  logic [TW-1:0]    oi [4];                    // Open interval times
  logic [TW-1:0]    rsd;                       // Reclose reset time
  logic [TW-1:0]    rsld;                      // Lockout reset time
  logic             chg_pend;                  // Settings changed
  arsr_state_t      state;                     // Sequencer state
  logic [2:0]       shot;                      // Shot counter
  logic             oi_armed;                  // Initiated, interval due
  logic [TW-1:0]    oi_cnt;                    // Interval remaining
  logic [TW-1:0]    rst_el;                    // Reset time elapsed
  logic             force_lo;                  // Use lockout time
  logic             close_out;                 // Close output
  logic             ri_prev;                   // Initiate last tick
  logic             trip_prev;                 // Trip last tick
  logic             seq_prev;                  // Coordination last tick

  // Byte-lane merge for a setting register
  function automatic logic [TW-1:0] merge(input logic [TW-1:0] old,
                                          input logic [31:0]   nw,
                                          input logic [3:0]    sel);
    logic [31:0] v;
    v = 32'(old);
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        v[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return v[TW-1:0];
  endfunction

  // Count of nonzero intervals ahead of the first zero one
  function automatic logic [2:0] last_shot_f(input logic [TW-1:0] a,
                                             input logic [TW-1:0] b,
                                             input logic [TW-1:0] c,
                                             input logic [TW-1:0] d);
    logic [2:0] n;
    n = 3'h0;
    if (a != '0) begin
      n = 3'h1;
      if (b != '0) begin
        n = 3'h2;
        if (c != '0) begin
          n = 3'h3;
          if (d != '0) begin
            n = 3'h4;
          end
        end
      end
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Combinational decode
  logic          wr;                           // Accepted write
  logic          defeated;                     // Reclosing defeated
  logic [2:0]    last_shot;                    // Last shot value
  logic          ri_now;                       // Selected initiate
  logic          sup_now;                      // Selected supervision
  logic          ri_edge;                      // Initiate rising edge
  logic          trip_edge;                    // Trip rising edge
  logic          seq_edge;                     // Coordination edge
  logic          oi_run;                       // Interval timing
  logic          oi_exp;                       // Interval expires
  logic          rst_run;                      // Reset timer counting
  logic          rst_exp;                      // Reset timer expires
  logic [TW-1:0] rst_dur;                      // Active reset duration

  // Write lands at the edge where the master samples ack high
  assign wr = wb_cyc & wb_stb & wb_we & wb_ack;
  assign last_shot = last_shot_f(oi[0], oi[1], oi[2], oi[3]);
  assign defeated = ~ctrl[`ARSR_CTRL_EN] | (oi[0] == '0);
  assign ri_now  = ctrl[`ARSR_CTRL_BRKI] ? ~breaker_closed_status
                                          : reclose_initiate;
  assign sup_now = ctrl[`ARSR_CTRL_BRKI] ? trip : initiate_supervision;
  // edges sampled on the processing tick
  assign ri_edge   = proc_tick & ri_now & ~ri_prev;
  assign trip_edge = proc_tick & trip & ~trip_prev;
  assign seq_edge  = proc_tick & sequence_coordination & ~seq_prev;
  // timing only in cycle, initiated and not stalled
  assign oi_run = (state == ST_CYCLE) & oi_armed & ~stall_open_interval
                  & ~defeated;
  assign oi_exp = proc_tick & oi_run & (oi_cnt <= TW'(1));
  // cycle or coordination uses reclose time; lockout time
  // sequence coordination shots time with the reclose time
  // two independent durations, either may be longer
  assign rst_dur = (force_lo | (state == ST_LOCKOUT)) ? rsld : rsd;
  // counts only with breaker closed; block halts it
  assign rst_run = breaker_closed_status & ~reset_timing_block & ~defeated
                   & ((state != ST_RESET) | (shot != 3'h0)) & ~oi_armed;
  assign rst_exp = proc_tick & rst_run & ((rst_el + TW'(1)) >= rst_dur);

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_ack   <= 1'b0;
      wb_dat_r <= 32'h0;
    end else begin
      wb_ack   <= wb_cyc & wb_stb & ~wb_ack;
      wb_dat_r <= 32'h0;
      case (wb_adr)
        `ARSR_ADR_CTRL: wb_dat_r <= 32'(ctrl);
        `ARSR_ADR_OI1:  wb_dat_r <= 32'(oi[0]);
        `ARSR_ADR_OI2:  wb_dat_r <= 32'(oi[1]);
        `ARSR_ADR_OI3:  wb_dat_r <= 32'(oi[2]);
        `ARSR_ADR_OI4:  wb_dat_r <= 32'(oi[3]);
        `ARSR_ADR_RSD:  wb_dat_r <= 32'(rsd);
        `ARSR_ADR_RSLD: wb_dat_r <= 32'(rsld);
        `ARSR_ADR_STAT: wb_dat_r <= 32'(status);
        default:        wb_dat_r <= 32'h0;
      endcase
    end
  end

  // Setting registers; a write at or below ARSR_ADR_RSLD counts as a settings change
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl     <= `ARSR_RST_CTRL;
      oi[0]    <= `ARSR_RST_OI1;
      oi[1]    <= `ARSR_RST_OIX;
      oi[2]    <= `ARSR_RST_OIX;
      oi[3]    <= `ARSR_RST_OIX;
      rsd      <= `ARSR_RST_RSD;
      rsld     <= `ARSR_RST_RSLD;
      chg_pend <= 1'b1;                        // Power-up acts as a change
    end else begin
      chg_pend <= group_switch;
      if (wr) begin
        chg_pend <= (wb_adr <= `ARSR_ADR_RSLD) | group_switch;
        case (wb_adr)
          `ARSR_ADR_CTRL: if (wb_sel[0]) begin
            ctrl <= wb_dat_w[2:0];
          end
          `ARSR_ADR_OI1:  oi[0] <= merge(oi[0], wb_dat_w, wb_sel);
          `ARSR_ADR_OI2:  oi[1] <= merge(oi[1], wb_dat_w, wb_sel);
          `ARSR_ADR_OI3:  oi[2] <= merge(oi[2], wb_dat_w, wb_sel);
          `ARSR_ADR_OI4:  oi[3] <= merge(oi[3], wb_dat_w, wb_sel);
          `ARSR_ADR_RSD:  rsd   <= merge(rsd, wb_dat_w, wb_sel);
          `ARSR_ADR_RSLD: rsld  <= merge(rsld, wb_dat_w, wb_sel);
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge history; initiate starts high so power-up never initiates
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ri_prev   <= 1'b1;
      trip_prev <= 1'b1;
      seq_prev  <= 1'b1;
    end else if (proc_tick) begin
      ri_prev   <= ri_now;
      trip_prev <= trip;
      seq_prev  <= sequence_coordination;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: state, shot counter, open interval timer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state    <= ST_LOCKOUT;
      shot     <= 3'h0;
      oi_armed <= 1'b0;
      oi_cnt   <= '0;
    end else if (chg_pend) begin
      // keep state, drive shot to the new last shot
      shot     <= last_shot;
      oi_armed <= 1'b0;
    end else if (proc_tick && defeated) begin
      oi_armed <= 1'b0;                        // No automatic reclosing
    end else if (proc_tick) begin
      if (oi_run) begin
        oi_cnt <= oi_cnt - TW'(1);
      end
      case (state)
        ST_RESET, ST_CYCLE: begin
          if (rst_exp) begin
            state <= ST_RESET;
            shot  <= 3'h0;
          end else if (ri_edge) begin
            // unsupervised edge or no shot left
            if (!sup_now || oi_armed || shot >= last_shot) begin
              state    <= ST_LOCKOUT;
              oi_armed <= 1'b0;
            end else begin
              // supervised edge arms the interval of this shot
              // each interval starts on its own initiation
              state    <= ST_CYCLE;
              oi_armed <= 1'b1;
              oi_cnt   <= oi[shot[1:0]];
            end
          end else if (trip_edge && oi_armed && !breaker_closed_status) begin
            state    <= ST_LOCKOUT;
            oi_armed <= 1'b0;
          end else if (oi_exp) begin
            oi_armed <= 1'b0;
            if (shot < last_shot) begin
              shot <= shot + 3'h1;
            end
          end else if (seq_edge && shot < `ARSR_SHOT_MAX) begin
            shot <= shot + 3'h1;
          end
        end
        ST_LOCKOUT: begin
          // leave lockout only after the reset timer expires
          if (rst_exp) begin
            state <= ST_RESET;
            shot  <= 3'h0;
          end
        end
        default: state <= ST_LOCKOUT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset timer, counted up so a duration change applies at once
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rst_el   <= '0;
      force_lo <= 1'b1;
    end else if (chg_pend) begin
      rst_el   <= '0;
      force_lo <= 1'b1;
    end else if (proc_tick) begin
      if (!breaker_closed_status || rst_exp) begin
        // breaker open restarts the full duration
        rst_el <= '0;
        if (rst_exp) begin
          force_lo <= 1'b0;
        end
      end else if (rst_run) begin
        rst_el <= rst_el + TW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Close output; holding it covers a slow breaker status contact
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      close_out <= 1'b0;
    end else if (breaker_closed_status) begin
      close_out <= 1'b0;
    end else if (oi_exp || (proc_tick && close_conditions)) begin
      close_out <= 1'b1;
    end else if (trip && ctrl[`ARSR_CTRL_CLOSE_UNLATCH]) begin
      // only an unlatching setup drops close on trip
      close_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered status outputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status <= '0;
    end else begin
      status.close_out <= close_out;
      status.reset_timing_flag <= rst_run;
      status.open_interval_timing_flag <= oi_run;
      status.shot <= shot;
      // one-hot shot; all forced low when defeated
      status.pos <= defeated ? arsr_shot_pos_t'(5'h00)
                             : arsr_shot_pos_t'(5'h01 << shot);
      status.reset_state_flag   <= ~defeated & (state == ST_RESET);
      status.cycle_state_flag   <= ~defeated & (state == ST_CYCLE);
      status.lockout_state_flag <= ~defeated & (state == ST_LOCKOUT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  AST_RESET_NEEDS_CLOSED: assert property (
    (state == ST_RESET && $past(state) != ST_RESET)
      |-> $past(breaker_closed_status))
    else $error("Reset state entered without closed breaker");
  AST_SHOT_CLEARS: assert property (
    (state == ST_RESET && $past(state) != ST_RESET) |-> shot == 3'h0)
    else $error("Shot not cleared on reset");
  AST_OI_FLAG: assert property (
    status.open_interval_timing_flag |-> $past(state == ST_CYCLE && oi_armed))
    else $error("Interval flag outside timing");
  AST_UNSUP_LOCKOUT: assert property (
    (ri_edge && !sup_now && !defeated && !chg_pend && !rst_exp
     && state != ST_LOCKOUT) |=> state == ST_LOCKOUT)
    else $error("Unsupervised initiate did not lock out");
  AST_SUP_STARTS: assert property (
    (ri_edge && sup_now && state == ST_RESET && !defeated && !chg_pend
     && !rst_exp && shot < last_shot) |=> (state == ST_CYCLE && oi_armed)
       ##1 (stall_open_interval || status.open_interval_timing_flag))
    else $error("Supervised initiate did not start timing");
  AST_SHOT_STEP: assert property (
    (shot > $past(shot) && !$past(chg_pend)) |-> shot == $past(shot) + 3'h1)
    else $error("Shot jumped");
  AST_SHOT_SAT: assert property (
    ($past(oi_exp) && !$past(chg_pend)) |-> shot <= last_shot)
    else $error("Shot passed last shot");
  AST_ONE_HOT: assert property (
    !$past(defeated) |-> status.pos == arsr_shot_pos_t'(5'h01 << $past(shot)))
    else $error("Shot bits wrong");
  AST_DEFEAT: assert property (
    $past(defeated) |-> (status.pos == '0 && !status.cycle_state_flag
      && !status.reset_state_flag && !status.lockout_state_flag))
    else $error("Defeat did not clear flags");
  AST_CLOSE_HOLD: assert property (
    (close_out && !ctrl[`ARSR_CTRL_CLOSE_UNLATCH] && !breaker_closed_status)
      |=> close_out)
    else $error("Close dropped before breaker closed");
  AST_LOAD_LOCKOUT: assert property (
    chg_pend |=> (rst_el == '0 && force_lo && rst_dur == rsld))
    else $error("Reset timer not loaded with lockout time");

  COV_CYCLE:    cover property (state == ST_RESET ##1 state == ST_CYCLE);
  COV_RECLOSE:  cover property (oi_exp ##[1:20] close_out);
  COV_LOCKOUT:  cover property (ri_edge && !sup_now ##1 state == ST_LOCKOUT);
  COV_RESETDONE: cover property (state == ST_LOCKOUT ##1 state == ST_RESET);

endmodule

// ### testbench/arsr_brk_model.sv
/*
 * Circuit breaker model: the auxiliary contact follows trip and close coils.
 * Assumes the coil commands are synchronous to sys_clk.
 */
`timescale 1ns/1ps

module arsr_brk_model #(
  parameter int DLY = 3                   // Mechanism travel, clocks
) (
  input  wire logic sys_clk,              // Clock
  input  wire logic trip,                 // Trip coil
  input  wire logic close_cmd,            // Close coil
  input  wire logic force_open,           // Trip from outside the relay
  output logic      closed                // Auxiliary contact, high closed
);
  int cnt = 0;                            // Travel counter

  initial closed = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Contact moves only after a steady command; trip beats close, as the
  // anti-pump circuit would make it
  always @(posedge sys_clk) begin
    if ((trip || force_open) && closed) begin
      cnt <= cnt + 1;
    end else if (close_cmd && !closed && !trip) begin
      cnt <= cnt + 1;
    end else begin
      cnt <= 0;
    end
    if (cnt == DLY) begin
      closed <= !closed;
      cnt <= 0;
    end
  end
endmodule

// ### testbench/tb_autoreclose_shot_reset_logic.sv
/*
 * Bench for the autoreclose sequencer: registers over Wishbone, reclose
 * cycles against a breaker model. Assumes a tick every 4 clocks.
 */
`timescale 1ns/1ps
`include "arsr_map.svh"

module tb_autoreclose_shot_reset_logic
  import arsr_pkg::*;
;
  logic         sys_clk = 1'b0;          // 200 MHz clock
  logic         sys_rst = 1'b1;          // Sync reset
  logic         tick = 1'b0;             // Processing tick
  logic [1:0]   tdiv = 2'h0;             // Tick divider
  logic         trip = 1'b0;             // Trip condition
  logic         ri = 1'b0;               // Initiate, follows trip
  logic         sup = 1'b0;              // Supervision
  logic         sup_kill = 1'b0;         // Forces supervision low
  logic         rtb = 1'b1;              // Block reset timing
  logic         close_c = 1'b0;          // Manual close
  logic         f_open = 1'b0;           // External opening
  logic         seq = 1'b0;              // Coordination operation
  logic         wb_cyc = 1'b0;           // Bus cycle
  logic         wb_stb = 1'b0;           // Bus strobe
  logic         wb_we = 1'b0;            // Bus write
  logic [7:0]   wb_adr = 8'h00;          // Bus address
  logic [31:0]  wb_dat_w = 32'h0;        // Bus write data
  logic [31:0]  wb_dat_r;                // Bus read data
  logic         wb_ack;                  // Bus acknowledge
  logic         brk;                     // Breaker contact
  arsr_status_t status;                  // Flags and shot
  int           n_mismatch = 0;          // Mismatches
  int           compares = 0;            // Comparisons
  int           cyc_n = 0;               // Timeout counter

  always #2.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Tick, initiate on trip, supervision = breaker closed or in cycle
  always @(posedge sys_clk) begin
    tdiv <= tdiv + 2'h1;
    tick <= (tdiv == 2'h3);
    ri <= trip;
    sup <= !sup_kill && (brk || status.cycle_state_flag);
    cyc_n <= cyc_n + 1;
  end

  // Hang guard, well above the few hundred cycles needed
  always @(posedge sys_clk) begin
    if (cyc_n == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  arsr_core dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .proc_tick(tick),
    .breaker_closed_status(brk), .trip(trip), .reclose_initiate(ri),
    .initiate_supervision(sup), .stall_open_interval(trip),
    .reset_timing_block(rtb), .sequence_coordination(seq),
    .close_conditions(close_c), .group_switch(1'b0), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hf),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .status(status));

  arsr_brk_model #(.DLY(3)) brk_u (.sys_clk(sys_clk), .trip(trip),
    .close_cmd(status.close_out), .force_open(f_open), .closed(brk));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Durations may land one tick either way of the setting
  task automatic chk_rng(input int got, input int lo, input int hi,
                         input string what);
    compares++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("ERROR %0t %s got %0d", $time, what, got);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    do @(posedge sys_clk); while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  function automatic logic [2:0] st();
    return {status.lockout_state_flag, status.cycle_state_flag,
            status.reset_state_flag};
  endfunction

  task automatic wait_st(input logic [2:0] want);
    do @(posedge sys_clk); while (st() !== want);
  endtask

  // Length of the next reset timing run, in ticks
  task automatic rt_len(output int n);
    n = 0;
    do @(posedge sys_clk); while (status.reset_timing_flag !== 1'b1);
    while (status.reset_timing_flag === 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
    n = n / 4;
  endtask

  // One fault: trip, breaker opens, trip clears, reclose command
  task automatic trip_shot();
    do @(posedge sys_clk); while (brk !== 1'b1);
    trip <= 1'b1;
    do @(posedge sys_clk); while (brk !== 1'b0);
    repeat (20) @(posedge sys_clk);
    chk(status.open_interval_timing_flag, 1'b0, "stall");
    trip <= 1'b0;
    do @(posedge sys_clk); while (status.open_interval_timing_flag !== 1'b1);
    do @(posedge sys_clk); while (status.close_out !== 1'b1);
  endtask

  // Manual close out of lockout, then lockout reset time
  task automatic recover();
    int n;
    close_c <= 1'b1;
    do @(posedge sys_clk); while (brk !== 1'b1);
    close_c <= 1'b0;
    rt_len(n);
    chk_rng(n, 4, 6, "lockout reset time");
    wait_st(3'b001);
    chk(status.shot, 3'h0, "shot cleared");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] q;
    wb_xfer(1'b0, `ARSR_ADR_CTRL, 32'h0, q);
    chk(q, {29'h0, `ARSR_RST_CTRL}, "ctrl reset");
    wb_xfer(1'b0, `ARSR_ADR_RSLD, 32'h0, q);
    chk(q, {12'h0, `ARSR_RST_RSLD}, "rsld reset");
    wb_xfer(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    chk({status.pos, st()}, 8'h00, "defeated flags");
  endtask

  // Last shot two; blocked, then lockout time after the changes
  task automatic t_cfg();
    logic [31:0] q;
    int n;
    wb_xfer(1'b1, `ARSR_ADR_OI1, 32'h3, q);
    wb_xfer(1'b1, `ARSR_ADR_OI2, 32'h4, q);
    wb_xfer(1'b1, `ARSR_ADR_RSD, 32'hc, q);
    wb_xfer(1'b1, `ARSR_ADR_RSLD, 32'h5, q);
    wb_xfer(1'b1, `ARSR_ADR_CTRL, 32'h3, q);
    wait_st(3'b100);
    chk(status.shot, 3'h2, "last shot");
    repeat (60) @(posedge sys_clk);
    chk({status.reset_timing_flag, st()}, 4'h4, "blocked");
    rtb <= 1'b0;
    rt_len(n);
    chk_rng(n, 4, 6, "power-up reset time");
    wait_st(3'b001);
    chk(status.pos, 5'b00001, "shot zero bit");
  endtask

  task automatic t_cycle();
    int n;
    trip_shot();
    chk(status.shot, 3'h1, "shot stepped");
    chk(status.pos, 5'b00010, "shot one bit");
    rt_len(n);
    chk_rng(n, 11, 13, "reclose reset time");
    wait_st(3'b001);
    chk(status.shot, 3'h0, "shot cleared");
  endtask

  // Coordination steps past last shot, then resets on reclose time
  task automatic t_seq();
    int n = 0;
    repeat (3) begin
      seq <= 1'b1;
      repeat (4) @(posedge sys_clk);
      seq <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    chk(status.shot, 3'h3, "past last shot");
    while (status.reset_timing_flag === 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
    chk_rng((n + 24) / 4, 12, 13, "coordination reset time");
    chk(status.shot, 3'h0, "coordination cleared");
  endtask

  // Every reclosure fails: saturates at last shot, then lockout
  task automatic t_fail();
    trip_shot();
    trip_shot();
    chk(status.pos, 5'b00100, "second interval");
    do @(posedge sys_clk); while (brk !== 1'b1);
    trip <= 1'b1;
    wait_st(3'b100);
    chk(status.shot, 3'h2, "saturated");
    do @(posedge sys_clk); while (brk !== 1'b0);
    trip <= 1'b0;
    recover();
  endtask

  task automatic t_sup();
    sup_kill <= 1'b1;
    trip <= 1'b1;
    wait_st(3'b100);
    chk(status.open_interval_timing_flag, 1'b0, "no timing");
    do @(posedge sys_clk); while (brk !== 1'b0);
    trip <= 1'b0;
    sup_kill <= 1'b0;
    recover();
  endtask

  // Breaker-open initiation; an opening without trip locks out
  task automatic t_mode1();
    logic [31:0] q;
    wb_xfer(1'b1, `ARSR_ADR_CTRL, 32'h5, q);
    f_open <= 1'b1;
    wait_st(3'b100);
    chk(status.open_interval_timing_flag, 1'b0, "external open");
    f_open <= 1'b0;
    recover();
  endtask

  task automatic give_verdict();
    $display("Counts: %0d mismatches, %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_cfg();
    t_cycle();
    t_seq();
    t_fail();
    t_sup();
    t_mode1();
    give_verdict();
  end
endmodule
